//--- hw/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.meta = pinIn;
    next_st.stable = st.meta;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pinSync = st.stable;
endmodule // pin_sync
`default_nettype wire

//--- hw/time_mark_delay_measurement.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmdm_consts.svh"
module time_mark_delay_measurement #(
  parameter int STEP_CYCLES = `TMDM_STEP_CYCLES,
  parameter int RTC_CYCLES = `TMDM_RTC_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [15:0] rdData,
  input wire logic [2:0] feedbackIn,
  input wire logic externalTickIn,
  input wire logic rtcIntIn,
  input wire logic tickInt,
  output logic markOut
);
  localparam logic [`TMDM_DIV_W-1:0] STEP_LAST = `TMDM_DIV_W'(STEP_CYCLES - 1);
  localparam logic [`TMDM_DIV_W-1:0] RTC_LAST = `TMDM_DIV_W'(RTC_CYCLES - 1);

  tmdm_pkg::state_t st;
  tmdm_pkg::state_t next_st;
  tmdm_pkg::pins_t pinRaw;
  tmdm_pkg::pins_t pinS;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign pinRaw = '{fb: feedbackIn, extTick: externalTickIn, rtcInt: rtcIntIn};

  pin_sync #(.WIDTH(5)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(pinRaw),
    .pinSync(pinS)
  );

  logic [2:0] fbRise;
  logic extRise;
  logic rtcRise;
  logic tickSel;
  logic fbHit;
  logic step;
  logic clearAll;
  logic rdLo;
  logic rdRtc;
  logic [`TMDM_CNT_W-1:0] readout;

  always_comb begin
    fbRise = pinS.fb & ~st.fbPrev;
    extRise = pinS.extTick & ~st.extPrev;
    rtcRise = pinS.rtcInt & ~st.rtcPrev;
    // external tick replaces the internal one when selected
    tickSel = st.tctl[`TMDM_EXTTICK_BIT] ? extRise : tickInt; // [R10]
    case (st.tctl[`TMDM_FBSEL_LSB +: 3]) // [R06]
      `TMDM_FBSEL_IN1: fbHit = fbRise[0];
      `TMDM_FBSEL_IN2: fbHit = fbRise[1];
      `TMDM_FBSEL_IN3: fbHit = fbRise[2];
      `TMDM_FBSEL_TICK: fbHit = tickSel;
      default: fbHit = 1'b0;
    endcase
    step = (st.stepDiv == STEP_LAST);
    clearAll = wrStrobe && hit(addr, `TMDM_ADDR_CLEAR_ALL);
    rdLo = rdStrobe && hit(addr, `TMDM_ADDR_DELAY_LO);
    rdRtc = rdStrobe && hit(addr, `TMDM_ADDR_RTC_INTERVAL);
    // complement turns the wrapped down count into steps minus one
    readout = ~st.down; // [R03]
  end

  always_comb begin
    next_st = st;
    next_st.fbPrev = pinS.fb;
    next_st.extPrev = pinS.extTick;
    next_st.rtcPrev = pinS.rtcInt;
    next_st.markOut = 1'b0;
    next_st.stepDiv = step ? '0 : st.stepDiv + 1'b1;

    if (wrStrobe && hit(addr, `TMDM_ADDR_TIMER_CTL)) begin
      next_st.tctl = wrData[7:0];
    end
    if (wrStrobe && hit(addr, `TMDM_ADDR_DELAY_HI)) begin
      next_st.preset[20:16] = wrData[4:0]; // [R14]
    end
    if (clearAll || rdLo) begin
      next_st.fbSeen = 1'b0; // [R16]
    end

    case (st.phase)
      tmdm_pkg::IDLE, tmdm_pkg::DONE: begin
      end
      tmdm_pkg::ARMED: begin
        if (tickSel) begin
          next_st.down = st.preset; // [R04] [R15]
          next_st.phase = tmdm_pkg::PRESET_RUN;
        end
      end
      tmdm_pkg::PRESET_RUN: begin
        if (step) begin
          if (st.down == '0) begin
            next_st.markOut = 1'b1; // [R15]
            next_st.phase = tmdm_pkg::MEASURE;
          end else begin
            next_st.down = st.down - 1'b1; // [R18]
          end
        end
      end
      tmdm_pkg::MEASURE: begin
        if (fbHit) begin
          next_st.phase = tmdm_pkg::DONE; // [R06]
          next_st.fbSeen = 1'b1; // [R16]
        end else if (step) begin
          next_st.down = st.down - 1'b1; // [R05] [R18]
          if (~(st.down - 1'b1) == `TMDM_TIMEOUT_READ) begin
            next_st.phase = tmdm_pkg::DONE; // [R07]
          end
        end
      end
      default: next_st.phase = tmdm_pkg::IDLE;
    endcase

    // a rewrite of the low preset re-arms even mid-measurement
    if (wrStrobe && hit(addr, `TMDM_ADDR_DELAY_LO)) begin
      next_st.preset[15:0] = wrData;
      next_st.down = {st.preset[20:16], wrData}; // [R04]
      next_st.phase = tmdm_pkg::ARMED; // [R15]
    end

    next_st.rtcPre = (st.rtcPre == RTC_LAST) ? '0 : st.rtcPre + 1'b1;
    if (rdRtc || clearAll) begin
      next_st.rtcSeen = 1'b0; // [R13]
      next_st.rtcProt = 1'b0; // [R12]
    end
    if (rtcRise) begin
      next_st.rtcRun = 1'b1;
      next_st.rtcCnt = '0;
      next_st.rtcPre = '0;
    end else if (st.rtcRun && tickSel) begin
      next_st.rtcRun = 1'b0;
      if (!st.rtcProt) begin
        next_st.rtcReg = st.rtcCnt; // [R12]
        next_st.rtcProt = 1'b1; // [R12]
        next_st.rtcSeen = 1'b1; // [R17]
      end
    end else if (st.rtcRun && st.rtcPre == RTC_LAST && st.rtcCnt != 16'hffff) begin
      // saturates rather than wrapping on a missing tick
      next_st.rtcCnt = st.rtcCnt + 1'b1; // [R09] [R11]
    end

    if (hit(addr, `TMDM_ADDR_DELAY_LO)) begin
      next_st.rdData = readout[15:0]; // [R01]
    end else if (hit(addr, `TMDM_ADDR_DELAY_HI)) begin
      next_st.rdData = {11'h000, readout[20:16]}; // [R02]
    end else if (hit(addr, `TMDM_ADDR_RTC_INTERVAL)) begin
      next_st.rdData = st.rtcReg; // [R09]
    end else if (hit(addr, `TMDM_ADDR_STATUS)) begin
      next_st.rdData = 16'h0000;
      next_st.rdData[`TMDM_STAT_FB_BIT] = st.fbSeen;
      next_st.rdData[`TMDM_STAT_RTC_BIT] = st.rtcSeen;
    end else begin
      next_st.rdData = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdData = st.rdData;
  assign markOut = st.markOut;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_LO_MAP: assert property ($past(addr) == `TMDM_ADDR_DELAY_LO |-> rdData == ~$past(st.down[15:0])) // [R01]
    else $error("low delay read mismatch");
  AST_HI_ZERO: assert property ($past(addr) == `TMDM_ADDR_DELAY_HI |-> rdData[15:5] == 11'h000 &&
    rdData[4:0] == ~$past(st.down[20:16])) // [R02]
    else $error("high delay read mismatch");
  AST_ARM: assert property (wrStrobe && addr == `TMDM_ADDR_DELAY_LO |=> st.phase == tmdm_pkg::ARMED) // [R15]
    else $error("low preset write did not arm");
  AST_LOAD: assert property (st.phase == tmdm_pkg::ARMED && tickSel && !wrStrobe |=>
    st.down == $past(st.preset) && st.phase == tmdm_pkg::PRESET_RUN) // [R04]
    else $error("preset not loaded on tick");
  AST_MARK: assert property (st.phase == tmdm_pkg::PRESET_RUN && step && st.down == '0 && !wrStrobe |=>
    markOut && st.phase == tmdm_pkg::MEASURE) // [R15]
    else $error("mark not issued at zero");
  AST_WRAP: assert property (st.phase == tmdm_pkg::MEASURE && st.down == '0 && step && !fbHit && !wrStrobe |=>
    st.down == 21'h1fffff) // [R05]
    else $error("counter did not wrap");
  AST_STEP: assert property (st.phase == tmdm_pkg::PRESET_RUN && !step && !wrStrobe |=> $stable(st.down)) // [R18]
    else $error("counter moved between steps");
  AST_FREEZE: assert property (st.phase == tmdm_pkg::DONE && !wrStrobe |=> $stable(st.down)) // [R06]
    else $error("frozen count changed");
  AST_TIMEOUT: assert property (st.phase == tmdm_pkg::MEASURE && st.down == 21'h000003 && step && !fbHit &&
    !wrStrobe |=> st.phase == tmdm_pkg::DONE && !$rose(st.fbSeen) ##1 readout == `TMDM_TIMEOUT_READ) // [R07]
    else $error("timeout value wrong");
  AST_FBSEEN: assert property (st.phase == tmdm_pkg::MEASURE && fbHit && !wrStrobe |=> st.fbSeen) // [R16]
    else $error("feedback flag not set");
  AST_RTC_CLR: assert property (rdRtc && !(st.rtcRun && tickSel) |=> !st.rtcSeen) // [R13]
    else $error("rtc flag not cleared");
  AST_RTC_HOLD: assert property (st.rtcProt && !rdRtc && !clearAll |=> $stable(st.rtcReg)) // [R12]
    else $error("protected interval overwritten");

  COV_MARK: cover property (markOut);
  COV_FEEDBACK: cover property (st.phase == tmdm_pkg::MEASURE && fbHit);
  COV_TIMEOUT: cover property (st.phase == tmdm_pkg::DONE && !st.fbSeen);
  COV_RTC: cover property (st.rtcRun && tickSel && !st.rtcProt);
endmodule // time_mark_delay_measurement
`default_nettype wire

//--- hw/tmdm_consts.svh
// Functional notes
// R01 - low delay register shows count bits 15..0
// R02 - high register shows bits 20..16, rest zero
// R03 - delay reads completed 50 ns steps minus one
// R04 - counter holds programmed preset before the mark
// R05 - counter wraps past zero after the mark
// R06 - selected feedback source freezes the counter
// R07 - timeout stops at 1F FFFD, no flag
// R08 - software reads delay only after feedback flag
// R09 - count 2.275 us steps from rtc interrupt
// R10 - external tick ends count when selected
// R11 - interval count ranges 0 to tick period
// R12 - interval latched on tick, then protected
// R13 - rtc flag cleared by read or clear-all
// R14 - preset sets tick-to-mark delay in 50 ns
// R15 - low preset write arms; tick loads preset
// R16 - feedback flag set on feedback, cleared by read
// R17 - rtc flag set by interrupt then tick
// R18 - counter decrements once per 50 ns step
`ifndef TMDM_CONSTS_SVH
`define TMDM_CONSTS_SVH

`define TMDM_ADDR_STATUS 8'h80
`define TMDM_ADDR_TIMER_CTL 8'hc2
`define TMDM_ADDR_RTC_INTERVAL 8'hc2
`define TMDM_ADDR_DELAY_LO 8'hc3
`define TMDM_ADDR_DELAY_HI 8'hc4
`define TMDM_ADDR_CLEAR_ALL 8'hca

`define TMDM_CNT_W 21
`define TMDM_TIMEOUT_READ 21'h1ffffd
`define TMDM_FBSEL_LSB 5
`define TMDM_EXTTICK_BIT 4
`define TMDM_FBSEL_IN1 3'h0
`define TMDM_FBSEL_IN2 3'h1
`define TMDM_FBSEL_IN3 3'h2
`define TMDM_FBSEL_TICK 3'h3
`define TMDM_STAT_FB_BIT 14
`define TMDM_STAT_RTC_BIT 15

`define TMDM_CLK_PS 25000
`define TMDM_STEP_PS 50000
`define TMDM_RTC_STEP_PS 2275000
`define TMDM_STEP_CYCLES (`TMDM_STEP_PS / `TMDM_CLK_PS)
`define TMDM_RTC_CYCLES (`TMDM_RTC_STEP_PS / `TMDM_CLK_PS)
`define TMDM_DIV_W 7

`endif

//--- hw/tmdm_pkg.sv
`include "tmdm_consts.svh"
package tmdm_pkg;
  typedef enum logic [2:0] {IDLE, ARMED, PRESET_RUN, MEASURE, DONE} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [`TMDM_CNT_W-1:0] down;
    logic [`TMDM_CNT_W-1:0] preset;
    logic [7:0] tctl;
    logic [`TMDM_DIV_W-1:0] stepDiv;
    logic markOut;
    logic fbSeen;
    logic [2:0] fbPrev;
    logic extPrev;
    logic rtcPrev;
    logic rtcRun;
    logic [`TMDM_DIV_W-1:0] rtcPre;
    logic [15:0] rtcCnt;
    logic [15:0] rtcReg;
    logic rtcProt;
    logic rtcSeen;
    logic [15:0] rdData;
  } state_t;

  typedef struct packed {
    logic [2:0] fb;
    logic extTick;
    logic rtcInt;
  } pins_t;
endpackage

//--- testbench/mark_return.sv
`timescale 1ns/10ps
`default_nettype none
module mark_return (
  input wire logic core_clk,
  input wire logic markOut,
  input wire logic [1:0] line,
  input wire logic [7:0] lag,
  output logic [2:0] fb
);
  // driver echo of the mark; held 4 clocks so the pin synchronizer cannot miss it
  // mark is looked at mid-cycle, away from the edge that launches it
  initial begin
    fb = 3'h0;
    forever begin
      @(negedge core_clk);
      if (markOut && line != 2'h3) begin
        repeat (lag) @(posedge core_clk);
        #1 fb[line] = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 fb = 3'h0;
      end
    end
  end
endmodule // mark_return
`default_nettype wire

//--- testbench/time_mark_delay_measurement_bench.sv
`timescale 1ns/10ps
`default_nettype none
module time_mark_delay_measurement_bench;
  logic core_clk, rst, wrStrobe, rdStrobe, extTick, rtcInt, tickInt, markOut;
  logic [7:0] addr, lag;
  logic [15:0] wrData, rdData, v, w;
  logic [2:0] fb;
  logic [1:0] line;
  int err_count, n_tests, cyc, t0, pre, e, i, h;
  time_mark_delay_measurement time_mark_delay_measurement_i (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .feedbackIn(fb),
    .externalTickIn(extTick), .rtcIntIn(rtcInt), .tickInt(tickInt), .markOut(markOut));
  mark_return mark_return_i (.core_clk(core_clk), .markOut(markOut), .line(line), .lag(lag), .fb(fb));
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic close_out;
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  task automatic cw(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input logic [31:0] got, input int lo, input int hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // strobe is lowered and one edge passes, so back-to-back calls never re-raise it in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wrData = d;
    wrStrobe = 1;
    cw(1);
    wrStrobe = 0;
    cw(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic s);
    addr = a;
    rdStrobe = s;
    cw(1);
    rdStrobe = 0;
    v = rdData;
    cw(1);
  endtask
  task automatic pulse_tick(input logic ext);
    if (ext) extTick = 1;
    else tickInt = 1;
    cw(1);
    tickInt = 0;
    extTick = 0;
  endtask
  task automatic rtc_run(input int n, input logic ext);
    rtcInt = 1;
    cw(n);
    rtcInt = 0;
    pulse_tick(ext);
    cw(6);
  endtask
  initial begin
    {rst, wrStrobe, rdStrobe, extTick, rtcInt, tickInt} = 6'h20;
    {addr, wrData, line, lag} = '0;
    void'($urandom(32'h8aaa6544));
    cw(3);
    rst = 0;
    rd(8'h80, 0);
    chk(v, 16'h0000);
    rd(8'h11, 1);
    chk(v, 16'h0000);
    for (i = 0; i < 4; i++) begin
      line = i[1:0];
      lag = 8'($urandom_range(2, 30));
      pre = $urandom_range(0, 40);
      wr(8'hc2, 16'(i << 5));
      wr(8'hc4, 16'h0000);
      wr(8'hc3, 16'(pre));
      pulse_tick(0);
      t0 = cyc;
      h = 0;
      while (markOut !== 1'b1 && h < 500) begin
        cw(1);
        h++;
      end
      chkr(cyc - t0, 2 * pre + 1, 2 * pre + 5);
      if (i == 3) begin
        cw(lag);
        pulse_tick(0);
      end
      e = (lag + (i == 3 ? 1 : 4)) / 2;
      h = 0;
      v = 16'h0;
      while (v[14] !== 1'b1 && h < 100) begin
        rd(8'h80, 0);
        h++;
      end
      chk(v[14], 1'b1);
      if (i == 2) begin
        wr(8'hca, 16'h0000);
        rd(8'h80, 0);
        chk(v[14], 1'b0);
      end
      rd(8'hc3, 1);
      w = v;
      rd(8'hc4, 0);
      chk(v[15:5], 11'h0);
      chkr(21'({v[4:0], w} + 21'h1), e - 2, e + 2);
      rd(8'h80, 0);
      chk(v[14], 1'b0);
    end
    for (i = 0; i < 2; i++) begin
      wr(8'hc2, 16'(i << 4));
      pre = $urandom_range(200, 2000);
      rtc_run(pre, i[0]);
      rd(8'h80, 0);
      chk(v[15], 1'b1);
      rd(8'hc2, 1);
      chkr(v, pre / 91 - 1, pre / 91 + 1);
      rd(8'h80, 0);
      chk(v[15], 1'b0);
    end
    rtc_run(300, 1);
    rd(8'hc2, 0);
    w = v;
    rtc_run(1500, 1);
    rd(8'hc2, 1);
    chk(v, w);
    rtc_run(300, 1);
    wr(8'hca, 16'h0000);
    rd(8'h80, 0);
    chk(v[15], 1'b0);
    close_out();
  end
endmodule // time_mark_delay_measurement_bench
`default_nettype wire
